// ---- swd_pkg.sv ----
package swd_pkg;

    // -------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------
    localparam int unsigned SWD_NUM_SRC = 3;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic SWD_FLAG_RST = 1'b0;
    localparam logic SWD_EDGE_RST = 1'b0;
    localparam logic SWD_RELEASE_RST = 1'b0;

    // -------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        SWD_RUN,
        SWD_STANDBY,
        SWD_WAKE
    } swd_state_t;

    typedef struct packed {
        logic [SWD_NUM_SRC-1:0] src_level;
        logic [SWD_NUM_SRC-1:0] src_enable;
    } swd_src_t;

    typedef struct packed {
        logic wakeup_flag_clear;
        logic standby_req;
    } swd_ctrl_t;

    typedef struct packed {
        logic wakeup_flag;
        logic in_standby;
        logic power_reset;
    } swd_stat_t;

    // -------------------------------------------------------------------
    // Status reset value
    // -------------------------------------------------------------------
    localparam swd_stat_t SWD_STAT_RST = '0;

endpackage : swd_pkg

// ---- swd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module swd_sync
    import swd_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    always_comb begin
        meta_next = d_i;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q_o = q_reg;

endmodule // swd_sync

`default_nettype wire

// ---- swd_detector.sv ----
`timescale 1ns/1ps
`default_nettype none

// Operation
// (R1) OR enabled sources into one rising-edge detector
// (R2) Flag set at standby entry wakes at once
// (R3) Writing clear bit clears flag; clear first
// (R4) Source held high across clear masks edges
// (R5) Software disables, clears, re-enables, then sleeps
// (R6) Source high at re-enable: wake, power reset
// (R7) Flag sticky until cleared, reads one
module swd_detector
    import swd_pkg::*;
(
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   rstn_i,
    // Wakeup sources (pins, asynchronous)
    input  wire logic [SWD_NUM_SRC-1:0] src_level_i,
    // Software control, same clock
    input  wire logic [SWD_NUM_SRC-1:0] src_enable_i,
    input  wire logic                   wakeup_flag_clear_i,
    input  wire logic                   standby_req_i,
    // Status
    output logic                        wakeup_flag_o,
    output logic                        in_standby_o,
    output logic                        power_reset_o
);

    // -------------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_meta_next;
    logic rst_sync_reg;
    logic rst_sync_next;
    logic rst_n;

    // Assertion is immediate, release waits two edges
    always_comb begin
        rst_meta_next = 1'b1;
        rst_sync_next = rst_meta_reg;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_reg <= SWD_RELEASE_RST;
            rst_sync_reg <= SWD_RELEASE_RST;
        end else begin
            rst_meta_reg <= rst_meta_next;
            rst_sync_reg <= rst_sync_next;
        end
    end

    assign rst_n = rst_sync_reg;

    // -------------------------------------------------------------------
    // Source synchronisation
    // -------------------------------------------------------------------
    swd_src_t                 src;
    swd_ctrl_t                ctrl;
    logic [SWD_NUM_SRC-1:0]   level_sync;

    swd_sync #(
        .WIDTH (SWD_NUM_SRC)
    ) u_sync (
        .clk_i  (sys_clk_i),
        .rstn_i (rst_n),
        .d_i    (src_level_i),
        .q_o    (level_sync)
    );

    assign src.src_level         = level_sync;
    assign src.src_enable        = src_enable_i;
    assign ctrl.wakeup_flag_clear = wakeup_flag_clear_i;
    assign ctrl.standby_req      = standby_req_i;

    function automatic logic combine(input swd_src_t s);
        combine = |(s.src_level & s.src_enable);
    endfunction

    // -------------------------------------------------------------------
    // Edge detector and sticky flag
    // -------------------------------------------------------------------
    logic combined;
    logic edge_prev_reg;
    logic edge_prev_next;
    logic flag_reg;
    logic flag_next;
    logic rise;

    // Single detector after the OR: an enabled source that stays high hides
    // edges of every other source until it falls again
    assign combined = combine(src);                              // R1
    assign rise     = combined & ~edge_prev_reg;                 // R1 R4

    always_comb begin
        edge_prev_next = combined;                               // R4
        flag_next      = flag_reg;
        if (ctrl.wakeup_flag_clear) begin
            flag_next = 1'b0;                                    // R3
        end
        // Set wins over a simultaneous clear
        if (rise) begin
            flag_next = 1'b1;                                    // R7
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            edge_prev_reg <= SWD_EDGE_RST;
            flag_reg      <= SWD_FLAG_RST;
        end else begin
            edge_prev_reg <= edge_prev_next;
            flag_reg      <= flag_next;
        end
    end

    // -------------------------------------------------------------------
    // Standby sequencer
    // -------------------------------------------------------------------
    swd_state_t state_reg;
    swd_state_t state_next;
    swd_stat_t  stat_reg;
    swd_stat_t  stat_next;

    // Decoded from the next state so every output leaves a flop
    function automatic swd_stat_t status_of(input swd_state_t s, input logic f);
        swd_stat_t st;
        st             = SWD_STAT_RST;
        st.wakeup_flag = f;                                      // R7
        case (s)
            SWD_STANDBY: begin
                st.in_standby = 1'b1;
            end
            SWD_WAKE: begin
                // Standby exit always restarts through a power reset
                st.power_reset = 1'b1;                           // R6
            end
            default: begin
                st.in_standby = 1'b0;
            end
        endcase
        status_of = st;
    endfunction

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SWD_RUN: begin
                // Entry is taken even with the flag set; exit follows
                if (ctrl.standby_req) begin
                    state_next = SWD_STANDBY;
                end
            end
            SWD_STANDBY: begin
                // Stale flag or a fresh edge both end standby
                if (flag_reg) begin
                    state_next = SWD_WAKE;                       // R2 R6
                end
            end
            SWD_WAKE: begin
                state_next = SWD_RUN;
            end
            default: begin
                state_next = SWD_RUN;
            end
        endcase
        stat_next = status_of(state_next, flag_next);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SWD_RUN;
            stat_reg  <= SWD_STAT_RST;
        end else begin
            state_reg <= state_next;
            stat_reg  <= stat_next;
        end
    end

    assign wakeup_flag_o = stat_reg.wakeup_flag;
    assign in_standby_o  = stat_reg.in_standby;
    assign power_reset_o = stat_reg.power_reset;

endmodule // swd_detector

`default_nettype wire

// ---- swd_detector_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module swd_detector_asserts
    import swd_pkg::*;
(
    input wire logic                   sys_clk_i,
    input wire logic                   rstn_i,
    input wire logic [SWD_NUM_SRC-1:0] src_level_i,
    input wire logic [SWD_NUM_SRC-1:0] src_enable_i,
    input wire logic                   wakeup_flag_clear_i,
    input wire logic                   standby_req_i,
    input wire logic                   wakeup_flag_o,
    input wire logic                   in_standby_o,
    input wire logic                   power_reset_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // Level settled through the synchroniser before enable rises
    chk_enable_edge: assert property ($stable(src_level_i) [*3] ##0 ($past(src_enable_i) == '0
        && (src_enable_i & src_level_i) != '0) |=> wakeup_flag_o) else $error("no flag on enable");
    chk_flag_sticky: assert property (wakeup_flag_o && !wakeup_flag_clear_i |=> wakeup_flag_o)
        else $error("flag lost");
    chk_clear_works: assert property (wakeup_flag_clear_i && src_enable_i == '0 |=> !wakeup_flag_o)
        else $error("flag not cleared");
    chk_standby_enter: assert property (standby_req_i && !in_standby_o && !power_reset_o
        |=> in_standby_o) else $error("standby not entered");
    chk_flag_wakes: assert property (in_standby_o && wakeup_flag_o
        |=> !in_standby_o && power_reset_o) else $error("no wake on flag");
    chk_stay_asleep: assert property (in_standby_o && !wakeup_flag_o |=> in_standby_o)
        else $error("left standby without flag");
    chk_reset_pulse: assert property (power_reset_o |=> !power_reset_o)
        else $error("power reset too long");
    chk_reset_cause: assert property ($rose(power_reset_o) |-> $past(in_standby_o))
        else $error("power reset outside wake");
endmodule // swd_detector_asserts
bind swd_detector swd_detector_asserts u_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .src_level_i(src_level_i), .src_enable_i(src_enable_i), .wakeup_flag_clear_i(wakeup_flag_clear_i),
    .standby_req_i(standby_req_i), .wakeup_flag_o(wakeup_flag_o), .in_standby_o(in_standby_o),
    .power_reset_o(power_reset_o));
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import swd_pkg::*;
    logic           sys_clk_i  = 1'b0;
    logic           rstn_i     = 1'b0;
    swd_src_t       src        = '0;
    swd_ctrl_t      ctl        = '0;
    wire logic      flag_w;
    wire logic      stby_w;
    wire logic      prst_w;
    logic [SWD_NUM_SRC-1:0] m_meta = '0;
    logic [SWD_NUM_SRC-1:0] m_sync = '0;
    logic           m_prev     = 1'b0;
    logic           m_comb     = 1'b0;
    logic           m_flag     = 1'b0;
    int             num_errors = 0;
    int             n_checks   = 0;
    int             seed;
    always #50 sys_clk_i = ~sys_clk_i;
    swd_detector uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .src_level_i(src.src_level),
        .src_enable_i(src.src_enable), .wakeup_flag_clear_i(ctl.wakeup_flag_clear),
        .standby_req_i(ctl.standby_req), .wakeup_flag_o(flag_w),
        .in_standby_o(stby_w), .power_reset_o(prst_w));
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // Sample at the falling edge, clear of the launch edge
    task automatic chk(input swd_stat_t exp);
        swd_stat_t got;
        @(negedge sys_clk_i);
        got = {flag_w, stby_w, prst_w};
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // Expected flag: a rising edge sets, a clear clears, set wins
    function automatic logic next_flag(input logic f, input logic clr, input logic rise);
        next_flag = rise | (f & ~clr);
    endfunction
    function automatic swd_stat_t want(input logic f, input logic s, input logic r);
        want = {f, s, r};
    endfunction
    task automatic prep(input logic [SWD_NUM_SRC-1:0] e);
        cyc(1);
        src.src_enable <= '0;
        ctl.wakeup_flag_clear <= 1'b1;
        cyc(1);
        ctl.wakeup_flag_clear <= 1'b0;
        src.src_enable <= e;
    endtask
    task automatic sleep();
        cyc(1);
        ctl.standby_req <= 1'b1;
        cyc(1);
        ctl.standby_req <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        seed = $urandom(90312);
        cyc(10);
        rstn_i <= 1'b1;
        cyc(3);
        // Random sources, enables and clears, modelled through two sync stages
        for (int k = 0; k < 200; k++) begin
            cyc(1);
            m_comb = |(m_sync & src.src_enable);
            m_flag = next_flag(m_flag, ctl.wakeup_flag_clear, m_comb & ~m_prev);
            m_prev = m_comb;
            m_sync = m_meta;
            m_meta = src.src_level;
            src <= 6'($urandom);
            ctl.wakeup_flag_clear <= (($urandom % 4) == 0);
            chk(want(m_flag, 1'b0, 1'b0));
        end
        cyc(1);
        src <= '0;
        ctl <= '0;
        cyc(3);
        // Disabled sources carry random noise
        for (int i = 0; i < SWD_NUM_SRC; i++) begin
            prep(3'h1 << i);
            src.src_level <= 3'($urandom) & ~(3'h1 << i);
            chk(3'b000);
            cyc(1);
            src.src_level[i] <= 1'b1;
            cyc(3);
            chk(3'b100);
            cyc(1);
            src.src_level <= '0;
            cyc(5);
            chk(3'b100);
        end
        sleep();
        chk(3'b110);
        chk(3'b101);
        chk(3'b100);
        prep(3'h7);
        sleep();
        chk(3'b010);
        cyc(20);
        chk(3'b010);
        cyc(1);
        src.src_level[2] <= 1'b1;
        cyc(3);
        chk(3'b110);
        chk(3'b101);
        // Source still high at re-enable
        prep(3'h4);
        sleep();
        chk(3'b110);
        chk(3'b101);
        cyc(1);
        ctl.wakeup_flag_clear <= 1'b1;
        cyc(1);
        ctl.wakeup_flag_clear <= 1'b0;
        chk(3'b000);
        cyc(1);
        src.src_enable <= 3'h5;
        src.src_level <= 3'h5;
        cyc(6);
        chk(3'b000);
        sleep();
        cyc(10);
        chk(3'b010);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
